// File: pkg/ssm_defs.vh
// Register offsets, field positions, reset values and codes of the secure state monitor
`ifndef SSM_DEFS_VH
`define SSM_DEFS_VH
// Register byte offsets
`define SSM_OFF_CTRL 12'h000
`define SSM_OFF_CMD 12'h004
`define SSM_OFF_STATE 12'h008
`define SSM_OFF_HPSTAT 12'h00C
`define SSM_OFF_VIOL 12'h010
`define SSM_OFF_RTCCFG 12'h014
`define SSM_OFF_RTC 12'h018
`define SSM_OFF_LPCTRL 12'h01C
`define SSM_OFF_LPSTAT 12'h020
`define SSM_OFF_SRTC_HI 12'h024
`define SSM_OFF_SRTC_LO 12'h028
`define SSM_OFF_ALARM 12'h02C
`define SSM_OFF_TAMPCFG 12'h030
`define SSM_OFF_TAMPSTAT 12'h034
`define SSM_OFF_KEY 12'h038
// Command register bits (write one to trigger)
`define SSM_CMD_TRANS 0
`define SSM_CMD_SV 1
`define SSM_CMD_FSV 2
`define SSM_CMD_LPRST 3
`define SSM_CMD_LPSV 4
// Control register bits
`define SSM_CTRL_MKS_EN 0
`define SSM_CTRL_RTC_EN 1
`define SSM_CTRL_SECBOOT 2
// High-power status bits
`define SSM_HP_PI 0
`define SSM_HP_ALARM 1
`define SSM_HP_ZMK_ZERO 2
`define SSM_HP_FMK_ZERO 3
// Violation status bits (0..5 are input violations)
`define SSM_SV_ZMK_ECC 6
`define SSM_SV_LP 7
`define SSM_SV_SW 8
`define SSM_SV_FSW 9
`define SSM_SV_LPSW 10
// Calibration / periodic config fields
`define SSM_CFG_CALEN 0
`define SSM_CFG_CAL_LSB 1
`define SSM_CFG_CAL_MSB 5
`define SSM_CFG_PIEN 6
`define SSM_CFG_PIF_LSB 8
`define SSM_CFG_PIF_MSB 11
// Low-power control bits
`define SSM_LP_SRTC_EN 0
`define SSM_LP_ALARM_EN 1
`define SSM_LP_ECC_EN 2
`define SSM_LP_MKMODE_LSB 4
`define SSM_LP_MKMODE_MSB 5
// Reset values
`define SSM_RST_CTRL 3'h0
`define SSM_RST_RTCCFG 12'h000
`define SSM_RST_LPCTRL 6'h00
`define SSM_RST_TAMPCFG 8'h00
// Security states
`define SSM_ST_INIT 3'h0
`define SSM_ST_HARD_FAIL 3'h1
`define SSM_ST_SOFT_FAIL 3'h2
`define SSM_ST_INIT_INTER 3'h3
`define SSM_ST_CHECK 3'h4
`define SSM_ST_NON_SECURE 3'h5
`define SSM_ST_TRUSTED 3'h6
`define SSM_ST_SECURE 3'h7
// Master key modes
`define SSM_MK_FUSED 2'h0
`define SSM_MK_ZERO 2'h1
`define SSM_MK_COMBINED 2'h2
`endif

// File: verif/ssm_assertions.sv
// Port-level assertions for the secure state monitor
`timescale 1ns/1ps
`default_nettype none
`include "ssm_defs.vh"
module ssm_chk #(
  parameter KW = 32, // Key width
  parameter PINS = 2 // Tamper pins
) (
  input wire logic core_clk, // Clock
  input wire logic rstn, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic [5:0] sv_in, // Violation pins
  input wire logic fab_cfg, // Fab strap
  input wire logic [PINS-1:0] tamper_pin, // Tamper pins
  input wire logic [KW-1:0] fused_master_key, // Fused key
  input wire logic [KW-1:0] zero_key, // Zeroizable key
  input wire logic zero_key_ecc_err, // ECC failure
  input wire logic [KW-1:0] master_key_q, // Selected key
  input wire logic hp_irq_q, // HP event
  input wire logic lp_irq_q // Secure alarm
);
  logic acc, wr, rd, lprst, clr, mks_q, aen_q;
  logic [1:0] mode_q;
  logic [3:0] seen_q;
  logic [KW-1:0] key_exp;
  // ==========================================
  // Bus decode
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign lprst = wr && paddr == `SSM_OFF_CMD && pwdata[`SSM_CMD_LPRST];
  assign clr = lprst || (wr && paddr == `SSM_OFF_LPSTAT && pwdata[0]);
  // Zeroizable paths count only with the HP enable set
  assign key_exp = (!mks_q || mode_q == 2'h0 || mode_q == 2'h3) ? fused_master_key :
    (mode_q == 2'h1) ? zero_key : fused_master_key ^ zero_key;
  // ==========================================
  // Shadow control fields rebuilt from bus writes
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mks_q <= 1'b0;
      aen_q <= 1'b0;
      mode_q <= 2'h0;
      seen_q <= 4'h0;
    end
    else
    begin
      if (wr && paddr == `SSM_OFF_CTRL)
        mks_q <= pwdata[`SSM_CTRL_MKS_EN];
      if (lprst)
      begin
        aen_q <= 1'b0;
        mode_q <= 2'h0;
      end
      else if (wr && paddr == `SSM_OFF_LPCTRL)
      begin
        aen_q <= pwdata[`SSM_LP_ALARM_EN];
        mode_q <= pwdata[5:4];
      end
      // Sticky flags once seen must never read back clear
      if (rd && paddr == `SSM_OFF_VIOL)
        seen_q <= seen_q | prdata[10:7];
    end
  end
  // ==========================================
  // Assertions
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  pready_high_a: assert property (pready)
    else $error("pready low");
  idle_rdata_a: assert property (!(psel && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside a read");
  unmapped_err_a: assert property (pslverr == (acc && (paddr > `SSM_OFF_KEY || paddr[1:0] != 2'h0)))
    else $error("error response wrong");
  key_select_a: assert property ($past(rstn) |-> master_key_q == $past(key_exp))
    else $error("master key wrong");
  alarm_gate_a: assert property ($rose(lp_irq_q) |-> $past(aen_q) || $past(aen_q, 2) || $past(aen_q, 3))
    else $error("alarm raised while disabled");
  alarm_sticky_a: assert property ($fell(lp_irq_q) |-> $past(clr) || $past(clr, 2) || $past(clr, 3))
    else $error("alarm flag fell without clear");
  fatal_soft_a: assert property ((wr && paddr == `SSM_OFF_CMD && pwdata[`SSM_CMD_FSV]) ##3
    (rd && paddr == `SSM_OFF_STATE) |-> prdata[2:0] == `SSM_ST_SOFT_FAIL)
    else $error("fatal violation missed soft fail");
  sticky_viol_a: assert property ((rd && paddr == `SSM_OFF_VIOL) |-> (prdata[10:7] & seen_q) == seen_q)
    else $error("sticky violation flag cleared");
endmodule
bind ssm_top ssm_chk #(.KW(KW), .PINS(PINS)) u_ssm_chk (
  .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sv_in(sv_in), .fab_cfg(fab_cfg),
  .tamper_pin(tamper_pin), .fused_master_key(fused_master_key), .zero_key(zero_key),
  .zero_key_ecc_err(zero_key_ecc_err), .master_key_q(master_key_q), .hp_irq_q(hp_irq_q), .lp_irq_q(lp_irq_q)
);
`default_nettype wire

// File: verif/tb_top.sv
// Self-checking bench for the secure state monitor
`timescale 1ns/1ps
`default_nettype none
`include "ssm_defs.vh"
module tb_top;
  localparam logic [31:0] FUSED = 32'h5A3C_0F96; // Arbitrary key pattern
  localparam logic [31:0] ZERO = 32'h0F1E_2D3C; // Arbitrary key pattern
  logic core_clk, rstn, psel, penable, pwrite, fab_cfg, ecc_err, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd, zkey;
  logic [5:0] sv_in;
  logic [1:0] tamper_pin;
  wire logic [31:0] prdata;
  wire logic [31:0] master_key_q;
  wire logic pready, pslverr, hp_irq_q, lp_irq_q;
  int n_errors = 0;
  int n_checks = 0;
  ssm_top dut (
    .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sv_in(sv_in), .fab_cfg(fab_cfg),
    .tamper_pin(tamper_pin), .fused_master_key(FUSED), .zero_key(zkey), .zero_key_ecc_err(ecc_err),
    .master_key_q(master_key_q), .hp_irq_q(hp_irq_q), .lp_irq_q(lp_irq_q)
  );
  // ==========================================
  // Clock and shared tasks
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer; returns mid-cycle so outputs have settled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Waits for ready however long it takes; only the watchdog ends a hang
    do
      @(posedge core_clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge core_clk);
  endtask
  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd & m);
  endtask
  task automatic cmd(input int b, input logic [2:0] e);
    apb(1'b1, `SSM_OFF_CMD, 32'h1 << b);
    rdchk("state", `SSM_OFF_STATE, 32'h7, {29'h0, e});
  endtask
  task automatic do_reset;
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(negedge core_clk);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_regs;
    rdchk("state", `SSM_OFF_STATE, 32'h7, `SSM_ST_CHECK);
    rdchk("ctrl", `SSM_OFF_CTRL, 32'hFFFFFFFF, `SSM_RST_CTRL);
    rdchk("rtccfg", `SSM_OFF_RTCCFG, 32'hFFFFFFFF, `SSM_RST_RTCCFG);
    rdchk("lpctrl", `SSM_OFF_LPCTRL, 32'hFFFFFFFF, `SSM_RST_LPCTRL);
    rdchk("tampcfg", `SSM_OFF_TAMPCFG, 32'hFFFFFFFF, `SSM_RST_TAMPCFG);
    rdchk("unmapped", 12'h03C, 32'hFFFFFFFF, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    $display("regs test done");
  endtask
  task automatic t_state;
    @(posedge core_clk);
    fab_cfg <= 1'b1;
    do_reset;
    cmd(`SSM_CMD_TRANS, `SSM_ST_TRUSTED);
    cmd(`SSM_CMD_SV, `SSM_ST_SOFT_FAIL);
    do_reset;
    cmd(`SSM_CMD_TRANS, `SSM_ST_TRUSTED);
    cmd(`SSM_CMD_TRANS, `SSM_ST_SECURE);
    cmd(`SSM_CMD_SV, `SSM_ST_SOFT_FAIL);
    @(posedge core_clk);
    fab_cfg <= 1'b0;
    do_reset;
    cmd(`SSM_CMD_FSV, `SSM_ST_SOFT_FAIL);
    do_reset;
    cmd(`SSM_CMD_SV, `SSM_ST_NON_SECURE);
    cmd(`SSM_CMD_TRANS, `SSM_ST_NON_SECURE);
    cmd(`SSM_CMD_FSV, `SSM_ST_SOFT_FAIL);
    cmd(`SSM_CMD_TRANS, `SSM_ST_NON_SECURE);
    do_reset;
    apb(1'b1, `SSM_OFF_CTRL, 32'h4);
    cmd(`SSM_CMD_TRANS, `SSM_ST_TRUSTED);
    cmd(`SSM_CMD_TRANS, `SSM_ST_SECURE);
    cmd(`SSM_CMD_TRANS, `SSM_ST_TRUSTED);
    cmd(`SSM_CMD_FSV, `SSM_ST_SOFT_FAIL);
    $display("state test done");
  endtask
  task automatic t_flags;
    do_reset;
    apb(1'b1, `SSM_OFF_CMD, 32'h2);
    @(posedge core_clk);
    sv_in <= 6'h3F;
    ecc_err <= 1'b1;
    zkey <= 32'h0;
    @(posedge core_clk);
    sv_in <= 6'h00;
    repeat (4) @(negedge core_clk);
    rdchk("viol set", `SSM_OFF_VIOL, 32'h7FF, 32'h13F);
    apb(1'b1, `SSM_OFF_VIOL, 32'h7FF);
    rdchk("viol clear", `SSM_OFF_VIOL, 32'h7FF, 32'h100);
    apb(1'b1, `SSM_OFF_LPCTRL, 32'h1 << `SSM_LP_ECC_EN);
    rdchk("ecc fail", `SSM_OFF_VIOL, 32'h40, 32'h40);
    @(posedge core_clk);
    ecc_err <= 1'b0;
    apb(1'b1, `SSM_OFF_VIOL, 32'h40);
    rdchk("ecc clear", `SSM_OFF_VIOL, 32'h40, 32'h0);
    apb(1'b1, `SSM_OFF_HPSTAT, 32'hC);
    rdchk("key zero", `SSM_OFF_HPSTAT, 32'hC, 32'h4);
    @(posedge core_clk);
    zkey <= ZERO;
    $display("flags test done");
  endtask
  task automatic t_rtc;
    logic [11:0] cf [3] = '{12'h01E, 12'h01F, 12'h021};
    int st [3] = '{32, 47, 16};
    logic [31:0] t0;
    apb(1'b1, `SSM_OFF_CTRL, 32'h2);
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, `SSM_OFF_RTCCFG, {20'h0, cf[i]});
      apb(1'b0, `SSM_OFF_RTC, 32'h0);
      t0 = rd;
      apb(1'b0, `SSM_OFF_RTC, 32'h0);
      chk("rtc step", st[i] * 3, rd - t0);
    end
    apb(1'b1, `SSM_OFF_RTCCFG, 32'hF40);
    apb(1'b1, `SSM_OFF_HPSTAT, 32'h1);
    repeat (50) @(negedge core_clk);
    chk("slow tick", 32'h0, {31'h0, hp_irq_q});
    apb(1'b1, `SSM_OFF_RTCCFG, 32'h040);
    repeat (8) @(negedge core_clk);
    chk("fast tick", 32'h1, {31'h0, hp_irq_q});
    apb(1'b1, `SSM_OFF_CTRL, 32'h0);
    rdchk("tick flag", `SSM_OFF_HPSTAT, 32'h1, 32'h1);
    apb(1'b1, `SSM_OFF_HPSTAT, 32'h1);
    rdchk("tick clear", `SSM_OFF_HPSTAT, 32'h1, 32'h0);
    $display("rtc test done");
  endtask
  task automatic t_keys;
    logic [31:0] ek [5] = '{FUSED, ZERO, FUSED ^ ZERO, FUSED, FUSED};
    logic [1:0] md [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2};
    for (int m = 0; m < 5; m++)
    begin
      apb(1'b1, `SSM_OFF_CTRL, {31'h0, m < 4});
      apb(1'b1, `SSM_OFF_LPCTRL, {26'h0, md[m], 4'h0});
      @(negedge core_clk);
      chk("master key", ek[m], master_key_q);
    end
    $display("key test done");
  endtask
  task automatic t_srtc;
    logic [31:0] t0;
    apb(1'b1, `SSM_OFF_SRTC_HI, 32'h1);
    apb(1'b1, `SSM_OFF_SRTC_LO, 32'hFFF0);
    apb(1'b1, `SSM_OFF_ALARM, 32'h2);
    apb(1'b1, `SSM_OFF_LPCTRL, 32'h3);
    chk("early alarm", 32'h0, {31'h0, lp_irq_q});
    repeat (30) @(negedge core_clk);
    chk("alarm", 32'h1, {31'h0, lp_irq_q});
    apb(1'b1, `SSM_OFF_LPCTRL, 32'h2);
    apb(1'b0, `SSM_OFF_SRTC_LO, 32'h0);
    t0 = rd;
    apb(1'b0, `SSM_OFF_SRTC_LO, 32'h0);
    chk("srtc held", t0, rd);
    apb(1'b1, `SSM_OFF_ALARM, 32'h5);
    apb(1'b1, `SSM_OFF_LPSTAT, 32'h1);
    repeat (3) @(negedge core_clk);
    chk("alarm clear", 32'h0, {31'h0, lp_irq_q});
    rdchk("hp alarm", `SSM_OFF_HPSTAT, 32'h2, 32'h2);
    apb(1'b1, `SSM_OFF_HPSTAT, 32'h2);
    rdchk("hp alarm clear", `SSM_OFF_HPSTAT, 32'h2, 32'h0);
    apb(1'b1, `SSM_OFF_CMD, 32'h1 << `SSM_CMD_LPRST);
    rdchk("srtc kept", `SSM_OFF_SRTC_HI, 32'hFFFFFFFF, 32'h2);
    rdchk("alarm kept", `SSM_OFF_ALARM, 32'hFFFFFFFF, 32'h5);
    rdchk("lp cleared", `SSM_OFF_LPCTRL, 32'hFFFFFFFF, 32'h0);
    $display("srtc test done");
  endtask
  task automatic t_tamper;
    @(posedge core_clk);
    tamper_pin <= 2'b10;
    repeat (5) @(negedge core_clk);
    rdchk("tamper low", `SSM_OFF_TAMPSTAT, 32'h3, 32'h1);
    rdchk("lp viol", `SSM_OFF_VIOL, 32'h80, 32'h80);
    @(posedge core_clk);
    tamper_pin <= 2'b11;
    apb(1'b1, `SSM_OFF_TAMPCFG, 32'hE8);
    apb(1'b1, `SSM_OFF_TAMPSTAT, 32'h3);
    @(posedge core_clk);
    tamper_pin <= 2'b01;
    repeat (4) @(posedge core_clk);
    tamper_pin <= 2'b11;
    repeat (6) @(negedge core_clk);
    rdchk("short glitch", `SSM_OFF_TAMPSTAT, 32'h3, 32'h0);
    @(posedge core_clk);
    tamper_pin <= 2'b01;
    repeat (14) @(negedge core_clk);
    rdchk("long pulse", `SSM_OFF_TAMPSTAT, 32'h3, 32'h2);
    $display("tamper test done");
  endtask
  // ==========================================
  // Main sequence and watchdog
  initial
  begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    fab_cfg = 1'b0;
    ecc_err = 1'b0;
    zkey = ZERO;
    sv_in = 6'h00;
    tamper_pin = 2'b11;
    do_reset;
    t_regs;
    t_state;
    t_flags;
    t_rtc;
    t_keys;
    t_srtc;
    t_tamper;
    close_out;
  end
  initial
  begin
    #(8 * 40000);
    n_errors++;
    $display("Error watchdog expected done seen timeout");
    close_out;
  end
endmodule
`default_nettype wire

// File: verilog/ssm_rtc_cnt.v
// Calibrated real-time counter with periodic tick output
`timescale 1ns/1ps
`default_nettype none
module ssm_rtc_cnt #(
  parameter WIDTH = 32 // Counter width
) (
  input wire core_clk, // Clock
  input wire rstn, // Async reset, active low
  input wire run, // Counter runs
  input wire cal_en, // Calibration enable
  input wire [4:0] cal_val, // Signed correction
  input wire [3:0] pi_sel, // Periodic tap select
  output reg [WIDTH-1:0] count_q, // Counter value
  output wire pi_tick // One-cycle periodic pulse
);
  // ==========================================
  // Counter with signed per-step correction
  // ==========================================
  wire [WIDTH-1:0] step;
  reg [WIDTH-1:0] prev_q;
  // Correction sign-extended; a plain step of 32 keeps -16 from stopping it
  assign step = cal_en ? ({{(WIDTH-6){1'b0}}, 6'h20} + {{(WIDTH-5){cal_val[4]}}, cal_val})
                       : {{(WIDTH-6){1'b0}}, 6'h20};
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      count_q <= {WIDTH{1'b0}};
      prev_q <= {WIDTH{1'b0}};
    end
    else
    begin
      prev_q <= count_q;
      if (run)
        count_q <= count_q + step;
    end
  end
  // Tick when the selected bit rises; bit 5+sel, so only bit 5 with a calibrated step above 32 can skip a tap
  assign pi_tick = count_q[pi_sel + 5'h05] & ~prev_q[pi_sel + 5'h05];
endmodule
`default_nettype wire

// File: verilog/ssm_tamper.v
// Passive tamper pin synchroniser, polarity and glitch filter
`timescale 1ns/1ps
`default_nettype none
module ssm_tamper #(
  parameter PINS = 2, // Number of tamper pins
  parameter FW = 3 // Filter counter width
) (
  input wire core_clk, // Clock
  input wire rstn, // Async reset, active low
  input wire [PINS-1:0] pin, // Raw tamper pins
  input wire [PINS-1:0] pol, // 1: active high
  input wire [PINS-1:0] flt_en, // Filter enable
  input wire [FW-1:0] flt_len, // Filter length in cycles
  output wire [PINS-1:0] hit // Per-pin detection level
);
  // ==========================================
  // Two-flop synchroniser then filter
  // ==========================================
  reg [PINS-1:0] s1_q;
  reg [PINS-1:0] s2_q;
  reg [FW-1:0] cnt_q [0:PINS-1];
  integer i;
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      // Reset to the high idle level so default active-low pins raise no false tamper
      s1_q <= {PINS{1'b1}};
      s2_q <= {PINS{1'b1}};
      for (i = 0; i < PINS; i = i + 1)
        cnt_q[i] <= {FW{1'b0}};
    end
    else
    begin
      s1_q <= pin;
      s2_q <= s1_q;
      // Counts consecutive active samples, saturating
      for (i = 0; i < PINS; i = i + 1)
        if ((s2_q[i] ~^ pol[i]) == 1'b0)
          cnt_q[i] <= {FW{1'b0}};
        else if (cnt_q[i] != {FW{1'b1}})
          cnt_q[i] <= cnt_q[i] + {{(FW-1){1'b0}}, 1'b1};
    end
  end
  genvar g;
  generate
    for (g = 0; g < PINS; g = g + 1)
    begin : g_pin
      // Fires on the sample completing length+1; works at the saturated maximum too
      assign hit[g] = flt_en[g] ? ((s2_q[g] ~^ pol[g]) & (cnt_q[g] >= flt_len)) : (s2_q[g] ~^ pol[g]);
    end
  endgenerate
endmodule
`default_nettype wire

// File: verilog/ssm_top.v
// Secure state monitor with calibrated clock, secure clock and tamper inputs
// ==========================================
`include "ssm_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module ssm_top #(
  parameter KW = 32, // Master key width
  parameter PINS = 2, // Tamper pins
  parameter FW = 3 // Filter counter width
) (
  input wire core_clk, // 125 MHz clock
  input wire rstn, // Async reset, active low
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction
  input wire [11:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output wire [31:0] prdata, // APB read data
  output wire pready, // APB ready
  output wire pslverr, // APB error
  input wire [5:0] sv_in, // Violation inputs 0-5, pins
  input wire fab_cfg, // Fab configuration strap, pin
  input wire [PINS-1:0] tamper_pin, // Passive tamper pins
  input wire [KW-1:0] fused_master_key, // One-time programmed key
  input wire [KW-1:0] zero_key, // Zeroizable key
  input wire zero_key_ecc_err, // ECC check failed, pin
  output reg [KW-1:0] master_key_q, // Selected master key
  output reg hp_irq_q, // Periodic or alarm event pending
  output reg lp_irq_q // Secure alarm pending
);
  // ==========================================
  // Pin synchronisers
  // ==========================================
  reg [7:0] pin_s1_q;
  reg [7:0] pin_s2_q;
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_s1_q <= 8'h00;
      pin_s2_q <= 8'h00;
    end
    else
    begin
      pin_s1_q <= {zero_key_ecc_err, fab_cfg, sv_in};
      pin_s2_q <= pin_s1_q;
    end
  end
  // ==========================================
  // APB decode
  // ==========================================
  wire wr = psel & penable & pwrite;
  wire known;
  assign pready = 1'b1; // Zero wait states
  assign pslverr = psel & penable & ~known;
  function hit_addr;
    input [11:0] a;
    input [11:0] off;
    begin
      hit_addr = (a == off);
    end
  endfunction
  // ==========================================
  // Registers
  // ==========================================
  reg [2:0] ctrl_q;
  reg [2:0] state_q;
  reg [3:0] hp_q;
  reg [10:0] viol_q;
  reg [11:0] rtccfg_q;
  reg [5:0] lpctrl_q;
  reg lp_alarm_q;
  reg [31:0] alarm_q;
  reg [47:0] srtc_q;
  reg [7:0] tampcfg_q;
  reg [PINS-1:0] tamp_q;
  reg [2:0] state_d;
  wire [31:0] rtc_cnt;
  wire pi_tick;
  wire [PINS-1:0] tamp_hit;
  wire cmd_wr = wr & hit_addr(paddr, `SSM_OFF_CMD);
  wire do_trans = cmd_wr & pwdata[`SSM_CMD_TRANS];
  wire do_sv = cmd_wr & pwdata[`SSM_CMD_SV];
  wire do_fsv = cmd_wr & pwdata[`SSM_CMD_FSV];
  wire do_lprst = cmd_wr & pwdata[`SSM_CMD_LPRST];
  wire do_lpsv = cmd_wr & pwdata[`SSM_CMD_LPSV];
  wire secure_boot = ctrl_q[`SSM_CTRL_SECBOOT] | pin_s2_q[6];
  wire srtc_alarm = (srtc_q[47:16] == alarm_q);
  wire zmk_zero = ~|zero_key;
  wire fmk_zero = ~|fused_master_key;
  // Security state machine; fatal beats plain violation beats transition, except in soft fail where transition wins
  always @*
  begin
    state_d = state_q;
    case (state_q)
      `SSM_ST_INIT: state_d = `SSM_ST_INIT_INTER;
      `SSM_ST_INIT_INTER: state_d = `SSM_ST_CHECK;
      `SSM_ST_CHECK:
      begin
        if (do_fsv)
          state_d = `SSM_ST_SOFT_FAIL;
        else if (do_sv)
          state_d = `SSM_ST_NON_SECURE;
        else if (do_trans)
          state_d = secure_boot ? `SSM_ST_TRUSTED : `SSM_ST_NON_SECURE;
      end
      `SSM_ST_NON_SECURE:
      begin
        if (do_fsv)
          state_d = `SSM_ST_SOFT_FAIL;
      end
      `SSM_ST_TRUSTED:
      begin
        if (do_fsv | do_sv)
          state_d = `SSM_ST_SOFT_FAIL;
        else if (do_trans)
          state_d = `SSM_ST_SECURE;
      end
      `SSM_ST_SECURE:
      begin
        if (do_fsv | do_sv)
          state_d = `SSM_ST_SOFT_FAIL;
        else if (do_trans)
          state_d = `SSM_ST_TRUSTED;
      end
      `SSM_ST_SOFT_FAIL:
      begin
        if (do_trans)
          state_d = `SSM_ST_NON_SECURE;
      end
      `SSM_ST_HARD_FAIL: state_d = `SSM_ST_HARD_FAIL;
      default: state_d = `SSM_ST_INIT;
    endcase
  end
  // High-power registers, flags: set wins over write-one-clear
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_q <= `SSM_RST_CTRL;
      state_q <= `SSM_ST_INIT;
      hp_q <= 4'h0;
      viol_q <= 11'h000;
      rtccfg_q <= `SSM_RST_RTCCFG;
    end
    else
    begin
      state_q <= state_d;
      if (wr & hit_addr(paddr, `SSM_OFF_CTRL))
        ctrl_q <= pwdata[2:0];
      if (wr & hit_addr(paddr, `SSM_OFF_RTCCFG))
        rtccfg_q <= pwdata[11:0];
      // Periodic and alarm clear on write-one; key-zero bits just track keys
      hp_q[`SSM_HP_PI] <= pi_tick | (hp_q[`SSM_HP_PI]
        & ~(wr & hit_addr(paddr, `SSM_OFF_HPSTAT) & pwdata[`SSM_HP_PI]));
      hp_q[`SSM_HP_ALARM] <= lp_alarm_q | (hp_q[`SSM_HP_ALARM]
        & ~(wr & hit_addr(paddr, `SSM_OFF_HPSTAT) & pwdata[`SSM_HP_ALARM]));
      hp_q[`SSM_HP_ZMK_ZERO] <= zmk_zero;
      hp_q[`SSM_HP_FMK_ZERO] <= fmk_zero;
      // Clearable violation bits: inputs 0-5 and key ECC failure
      viol_q[6:0] <= {pin_s2_q[7] & lpctrl_q[`SSM_LP_ECC_EN], pin_s2_q[5:0]}
        | (viol_q[6:0] & ~({7{wr & hit_addr(paddr, `SSM_OFF_VIOL)}} & pwdata[6:0]));
      // Sticky bits with no clear path
      viol_q[`SSM_SV_LP] <= viol_q[`SSM_SV_LP] | (|tamp_q);
      viol_q[`SSM_SV_SW] <= viol_q[`SSM_SV_SW] | do_sv;
      viol_q[`SSM_SV_FSW] <= viol_q[`SSM_SV_FSW] | do_fsv;
      viol_q[`SSM_SV_LPSW] <= viol_q[`SSM_SV_LPSW] | do_lpsv;
    end
  end
  // Low-power registers; section reset spares counter and alarm time
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lpctrl_q <= `SSM_RST_LPCTRL;
      lp_alarm_q <= 1'b0;
      tampcfg_q <= `SSM_RST_TAMPCFG;
      tamp_q <= {PINS{1'b0}};
      alarm_q <= 32'h00000000;
      srtc_q <= 48'h000000000000;
    end
    else
    begin
      if (do_lprst)
      begin
        lpctrl_q <= `SSM_RST_LPCTRL;
        lp_alarm_q <= 1'b0;
        tampcfg_q <= `SSM_RST_TAMPCFG;
        tamp_q <= {PINS{1'b0}};
      end
      else
      begin
        if (wr & hit_addr(paddr, `SSM_OFF_LPCTRL))
          lpctrl_q <= pwdata[5:0];
        if (wr & hit_addr(paddr, `SSM_OFF_TAMPCFG))
          tampcfg_q <= pwdata[7:0];
        lp_alarm_q <= (lpctrl_q[`SSM_LP_ALARM_EN] & srtc_alarm) | (lp_alarm_q
          & ~(wr & hit_addr(paddr, `SSM_OFF_LPSTAT) & pwdata[0]));
        tamp_q <= tamp_hit | (tamp_q
          & ~({PINS{wr & hit_addr(paddr, `SSM_OFF_TAMPSTAT)}} & pwdata[PINS-1:0]));
      end
      // Counter writes are allowed only while it is stopped
      if (lpctrl_q[`SSM_LP_SRTC_EN])
        srtc_q <= srtc_q + 48'h000000000001;
      else if (wr & hit_addr(paddr, `SSM_OFF_SRTC_HI))
        srtc_q[47:16] <= pwdata;
      else if (wr & hit_addr(paddr, `SSM_OFF_SRTC_LO))
        srtc_q[15:0] <= pwdata[15:0];
      if (wr & hit_addr(paddr, `SSM_OFF_ALARM))
        alarm_q <= pwdata;
    end
  end
  // Key select; without selection enable only the fused key is used
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      master_key_q <= {KW{1'b0}};
      hp_irq_q <= 1'b0;
      lp_irq_q <= 1'b0;
    end
    else
    begin
      hp_irq_q <= (hp_q[`SSM_HP_PI] & rtccfg_q[`SSM_CFG_PIEN]) | hp_q[`SSM_HP_ALARM];
      lp_irq_q <= lp_alarm_q;
      if (!ctrl_q[`SSM_CTRL_MKS_EN])
        master_key_q <= fused_master_key;
      else
        case (lpctrl_q[`SSM_LP_MKMODE_MSB:`SSM_LP_MKMODE_LSB])
          `SSM_MK_ZERO: master_key_q <= zero_key;
          `SSM_MK_COMBINED: master_key_q <= fused_master_key ^ zero_key;
          default: master_key_q <= fused_master_key;
        endcase
    end
  end
  // ==========================================
  // Submodules
  // ==========================================
  ssm_rtc_cnt #(.WIDTH(32)) u_rtc (
    .core_clk(core_clk),
    .rstn(rstn),
    .run(ctrl_q[`SSM_CTRL_RTC_EN]),
    .cal_en(rtccfg_q[`SSM_CFG_CALEN]),
    .cal_val(rtccfg_q[`SSM_CFG_CAL_MSB:`SSM_CFG_CAL_LSB]),
    .pi_sel(rtccfg_q[`SSM_CFG_PIF_MSB:`SSM_CFG_PIF_LSB]),
    .count_q(rtc_cnt),
    .pi_tick(pi_tick)
  );
  ssm_tamper #(.PINS(PINS), .FW(FW)) u_tamp (
    .core_clk(core_clk),
    .rstn(rstn),
    .pin(tamper_pin),
    .pol(tampcfg_q[PINS-1:0]),
    .flt_en(tampcfg_q[PINS+1:2]),
    .flt_len(tampcfg_q[7:5]),
    .hit(tamp_hit)
  );
  // ==========================================
  // Read mux, registered-source data except the key-zero bits at KEY
  // ==========================================
  reg [31:0] rd;
  reg k;
  always @*
  begin
    rd = 32'h00000000;
    k = 1'b1;
    case (paddr)
      `SSM_OFF_CTRL: rd = {29'h0, ctrl_q};
      `SSM_OFF_CMD: rd = 32'h00000000;
      `SSM_OFF_STATE: rd = {29'h0, state_q};
      `SSM_OFF_HPSTAT: rd = {28'h0, hp_q};
      `SSM_OFF_VIOL: rd = {21'h0, viol_q};
      `SSM_OFF_RTCCFG: rd = {20'h0, rtccfg_q};
      `SSM_OFF_RTC: rd = rtc_cnt;
      `SSM_OFF_LPCTRL: rd = {26'h0, lpctrl_q};
      `SSM_OFF_LPSTAT: rd = {31'h0, lp_alarm_q};
      `SSM_OFF_SRTC_HI: rd = srtc_q[47:16];
      `SSM_OFF_SRTC_LO: rd = {16'h0, srtc_q[15:0]};
      `SSM_OFF_ALARM: rd = alarm_q;
      `SSM_OFF_TAMPCFG: rd = {24'h0, tampcfg_q};
      `SSM_OFF_TAMPSTAT: rd = {{(32-PINS){1'b0}}, tamp_q};
      `SSM_OFF_KEY: rd = {30'h0, fmk_zero, zmk_zero};
      default: k = 1'b0;
    endcase
  end
  assign known = k;
  assign prdata = (psel & ~pwrite) ? rd : 32'h00000000;
endmodule
`default_nettype wire
